// file: rtl/cmd_bus_if.sv
// Parallel processor bus joining the host end and the device end.
`timescale 1ns/10ps
interface cmd_bus_if;
   logic cs_b;
   logic rd_b;
   logic wr_b;
   logic cmd_data_select;
   logic [15:0] hdata;
   logic hdata_oe;
   logic [15:0] ddata;
   logic ddata_oe;
   logic [15:0] data_bus;

   // Resolved level of the shared data lines; undriven lines read low.
   assign data_bus = ddata_oe ? ddata : (hdata_oe ? hdata : 16'h0000);

   modport host (output cs_b, rd_b, wr_b, cmd_data_select, hdata, hdata_oe,
                 input ddata, ddata_oe, data_bus);
   modport device (input cs_b, rd_b, wr_b, cmd_data_select, hdata, hdata_oe, data_bus,
                   output ddata, ddata_oe);
endinterface

// file: rtl/pkt_buffer.sv
// Endpoint packet buffer with a word port for the host bus and a byte port for USB.
`timescale 1ns/10ps
module pkt_buffer
   import usbcmd_pkg::*;
(
   input wire logic ref_clk_i,            // System clock.
   input wire logic rst_b_i,              // Asynchronous reset, active low.
   input wire logic ce_i,                 // Clock enable.
   input wire logic clear_i,              // Rewinds all pointers; stored words, count included, are kept.
   input wire logic hptr_rst_i,           // Rewinds the host word pointer.
   input wire logic hwr_i,                // Host word write.
   input wire logic [15:0] hwdata_i,      // Host write word.
   input wire logic hrd_i,                // Host word read advance.
   output logic [15:0] hrdata_o,          // Word at the host pointer.
   input wire logic pop_i,                // USB side requests next byte.
   output logic [7:0] byte_o,             // Popped byte.
   output logic bvalid_o,                 // Pulse, byte_o holds a payload byte.
   input wire logic usb_wr_i,             // USB side writes a byte.
   input wire logic [7:0] usb_byte_i,     // Byte from USB side.
   input wire logic usb_end_i             // USB side closes the packet.
);
   logic [15:0] mem [BUF_DEPTH];
   logic [BUF_AW-1:0] hptr_q;
   logic [BPTR_W-1:0] bptr_q;
   logic [BPTR_W-1:0] wptr_q;

   wire [15:0] count = mem[0];
   wire [BUF_AW-1:0] rd_word_idx = BUF_AW'(bptr_q[BPTR_W-1:1]) + BUF_AW'(1);
   wire [BUF_AW-1:0] wr_word_idx = BUF_AW'(wptr_q[BPTR_W-1:1]) + BUF_AW'(1);
   wire [15:0] rd_word = mem[rd_word_idx];
   wire more = 16'(bptr_q) < count;
   wire first_word_wr = hwr_i && (hptr_q == '0);

   assign hrdata_o = mem[hptr_q];

   // ==========================================================
   // Storage; word 0 is always the packet byte count.
   always_ff @(posedge ref_clk_i) begin
      if (ce_i) begin
         if (hwr_i) begin
            mem[hptr_q] <= hwdata_i;
         end else if (usb_end_i) begin
            mem[0] <= 16'(wptr_q);
         end else if (usb_wr_i && wptr_q[0]) begin
            mem[wr_word_idx][15:8] <= usb_byte_i;
         end else if (usb_wr_i) begin
            // Clearing the upper byte keeps the last word of an odd packet defined.
            mem[wr_word_idx] <= {8'h00, usb_byte_i};
         end
      end
   end

   // ==========================================================
   // Pointers.
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hptr_q <= '0;
         bptr_q <= '0;
         wptr_q <= '0;
         byte_o <= 8'h00;
         bvalid_o <= 1'b0;
      end else if (ce_i) begin
         bvalid_o <= 1'b0;
         if (clear_i || hptr_rst_i) begin
            hptr_q <= '0;
         end else if (hwr_i || hrd_i) begin
            hptr_q <= hptr_q + BUF_AW'(1);
         end
         if (clear_i || first_word_wr) begin
            bptr_q <= '0;
         end else if (pop_i && more) begin
            byte_o <= bptr_q[0] ? rd_word[15:8] : rd_word[7:0];
            bvalid_o <= 1'b1;
            bptr_q <= bptr_q + BPTR_W'(1);
         end
         if (clear_i || usb_end_i) begin
            wptr_q <= '0;
         end else if (usb_wr_i) begin
            wptr_q <= wptr_q + BPTR_W'(1);
         end
      end
   end
endmodule // pkt_buffer

// file: rtl/usb_cmd_device.sv
// Device end of the two-phase command port: phase decode, registers, buffers.
//
// Overview of operation
// - Select high: low data byte is command code.
// - Data-less commands act at once.
// - Select low: data moves to chosen target.
// - Multi-part registers go least significant first.
// - Upper byte ignored in command, narrow data.
// - Host uses whole aligned words only.
// - Odd IN packet: last upper byte unsent.
// - Host drops last upper byte, odd OUT.
// - Buffer starts with two-byte packet count.
// - Codes 20-2F write endpoint configurations.
// - Codes 30-3F read endpoint configurations.
// - B6/B7 write/read bus address.
// - B8/B9 write/read operating mode.
// - BA/BB write/read hardware configuration.
// - C2/C3 write/read interrupt enable, four bytes.
// - F0/F1 write/read DMA configuration.
// - F2/F3 write/read DMA counter, two bytes.
// - F6 resets all registers to defaults.
// - After resume, writes blocked until unlock.
// - Writing AA37 to unlock lifts protection.
`timescale 1ns/10ps
module usb_cmd_device
   import usbcmd_pkg::*;
(
   input wire logic ref_clk_i,            // System clock, 200 MHz.
   input wire logic rst_b_i,              // Asynchronous reset, active low.
   input wire logic ce_i,                 // Clock enable, freezes all state.
   cmd_bus_if.device bus,                 // Parallel processor bus.
   input wire logic resume_i,             // Pulse, wake-up from suspend.
   output logic locked_o,                 // Register writes blocked.
   output logic soft_reset_o,             // Pulse, reset-device command seen.
   output logic [7:0] dev_addr_o,         // Bus-address register.
   output logic [7:0] mode_o,             // Operating-mode register.
   output logic [15:0] hw_cfg_o,          // Hardware configuration register.
   output logic [31:0] int_en_o,          // Interrupt enable register.
   output logic [15:0] dma_cfg_o,         // DMA configuration register.
   output logic [15:0] dma_cnt_o,         // DMA transfer counter register.
   output logic [127:0] ep_cfg_o,         // Endpoint configurations, 8 bits each.
   input wire logic in_pop_i,             // USB engine takes next IN byte.
   output logic [7:0] in_byte_o,          // IN payload byte.
   output logic in_valid_o,               // Pulse, in_byte_o valid.
   input wire logic out_wr_i,             // USB engine writes an OUT byte.
   input wire logic [7:0] out_byte_i,     // OUT payload byte.
   input wire logic out_end_i             // USB engine closes the OUT packet.
);
   import usbcmd_pkg::*;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b01,
      PH_DATA = 2'b10
   } phase_t;

   phase_t phase_q;
   logic [7:0] cmd_q;
   logic [WIDX_W-1:0] widx_q;
   logic wr_act_q;
   logic rd_act_q;
   logic locked_q;
   logic [7:0] ep_cfg_q [EP_NUM];
   logic [15:0] outbuf_word;

   // ==========================================================
   // Bus strobes and phase decode
   wire wr_act = !bus.cs_b && !bus.wr_b;
   wire rd_act = !bus.cs_b && !bus.rd_b;
   wire wr_take = wr_act && !wr_act_q;
   wire rd_take = rd_act && !rd_act_q;
   wire cmd_take = wr_take && bus.cmd_data_select;
   wire dwr_take = wr_take && !bus.cmd_data_select && (phase_q == PH_DATA);
   wire drd_take = rd_take && !bus.cmd_data_select && (phase_q == PH_DATA);
   wire [7:0] code_in = bus.data_bus[7:0];
   wire [15:0] wdata = bus.data_bus;
   wire do_reset = cmd_take && (code_in == CMD_RESET_DEV);

   // ==========================================================
   // Command selection
   wire is_epw = cmd_q[7:4] == CMD_EPCFG_WR_HI[3:0];
   wire is_epr = cmd_q[7:4] == CMD_EPCFG_RD_HI[3:0];
   wire [3:0] ep_idx = cmd_q[3:0];
   wire is_unlock = cmd_q == CMD_UNLOCK;
   wire wr_ok = dwr_take && (!locked_q || is_unlock);
   wire wr_addr = wr_ok && (cmd_q == CMD_ADDR_WR);
   wire wr_mode = wr_ok && (cmd_q == CMD_MODE_WR);
   wire wr_hwcfg = wr_ok && (cmd_q == CMD_HWCFG_WR);
   wire wr_inten = wr_ok && (cmd_q == CMD_INTEN_WR) && (widx_q < INTEN_WORDS);
   wire wr_dmacfg = wr_ok && (cmd_q == CMD_DMACFG_WR);
   wire wr_dmacnt = wr_ok && (cmd_q == CMD_DMACNT_WR) && (widx_q == '0);
   wire wr_inbuf = wr_ok && (cmd_q == CMD_INBUF_WR);
   wire rd_outbuf = drd_take && (cmd_q == CMD_OUTBUF_RD);
   wire unlock_hit = dwr_take && is_unlock && (wdata == UNLOCK_KEY);
   wire buf_rewind = cmd_take;

   // Only listed codes open a data phase; anything else leaves the port idle.
   wire code_known = (code_in[7:4] == CMD_EPCFG_WR_HI[3:0]) ||
                     (code_in[7:4] == CMD_EPCFG_RD_HI[3:0]) ||
                     (code_in == CMD_ADDR_WR) || (code_in == CMD_ADDR_RD) ||
                     (code_in == CMD_MODE_WR) || (code_in == CMD_MODE_RD) ||
                     (code_in == CMD_HWCFG_WR) || (code_in == CMD_HWCFG_RD) ||
                     (code_in == CMD_INTEN_WR) || (code_in == CMD_INTEN_RD) ||
                     (code_in == CMD_DMACFG_WR) || (code_in == CMD_DMACFG_RD) ||
                     (code_in == CMD_DMACNT_WR) || (code_in == CMD_DMACNT_RD) ||
                     (code_in == CMD_UNLOCK) || (code_in == CMD_INBUF_WR) ||
                     (code_in == CMD_OUTBUF_RD);

   // Read data; upper byte of narrow registers reads as zero.
   wire [15:0] rd_word =
      is_epr ? {8'h00, ep_cfg_q[ep_idx]} :
      (cmd_q == CMD_ADDR_RD) ? {8'h00, dev_addr_o} :
      (cmd_q == CMD_MODE_RD) ? {8'h00, mode_o} :
      (cmd_q == CMD_HWCFG_RD) ? hw_cfg_o :
      (cmd_q == CMD_INTEN_RD && widx_q == 2'h0) ? int_en_o[15:0] :
      (cmd_q == CMD_INTEN_RD && widx_q == 2'h1) ? int_en_o[31:16] :
      (cmd_q == CMD_DMACFG_RD) ? dma_cfg_o :
      (cmd_q == CMD_DMACNT_RD && widx_q == 2'h0) ? dma_cnt_o :
      (cmd_q == CMD_OUTBUF_RD) ? outbuf_word :
      16'h0000;

   // ==========================================================
   // Phase tracking and bus drive
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase_q <= PH_IDLE;
         cmd_q <= 8'h00;
         widx_q <= '0;
         wr_act_q <= 1'b0;
         rd_act_q <= 1'b0;
         bus.ddata <= 16'h0000;
         bus.ddata_oe <= 1'b0;
         soft_reset_o <= 1'b0;
      end else if (ce_i) begin
         wr_act_q <= wr_act;
         rd_act_q <= rd_act;
         soft_reset_o <= do_reset;
         bus.ddata_oe <= rd_act && !bus.cmd_data_select;
         if (cmd_take) begin
            cmd_q <= code_in;
            widx_q <= '0;
            phase_q <= code_known ? PH_DATA : PH_IDLE;
         end else if (dwr_take || drd_take) begin
            if (widx_q != '1) begin
               widx_q <= widx_q + WIDX_W'(1);
            end
         end
         if (rd_take && !bus.cmd_data_select) begin
            bus.ddata <= drd_take ? rd_word : 16'h0000;
         end
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dev_addr_o <= ADDR_RST;
         mode_o <= MODE_RST;
         hw_cfg_o <= HWCFG_RST;
         int_en_o <= INTEN_RST;
         dma_cfg_o <= DMACFG_RST;
         dma_cnt_o <= DMACNT_RST;
      end else if (ce_i) begin
         if (do_reset) begin
            dev_addr_o <= ADDR_RST;
            mode_o <= MODE_RST;
            hw_cfg_o <= HWCFG_RST;
            int_en_o <= INTEN_RST;
            dma_cfg_o <= DMACFG_RST;
            dma_cnt_o <= DMACNT_RST;
         end else begin
            if (wr_addr) dev_addr_o <= wdata[7:0];
            if (wr_mode) mode_o <= wdata[7:0];
            if (wr_hwcfg) hw_cfg_o <= wdata;
            if (wr_inten && widx_q == 2'h0) int_en_o[15:0] <= wdata;
            if (wr_inten && widx_q == 2'h1) int_en_o[31:16] <= wdata;
            if (wr_dmacfg) dma_cfg_o <= wdata;
            if (wr_dmacnt) dma_cnt_o <= wdata;
         end
      end
   end

   // Write protection after resume; a resume in the unlock cycle keeps the lock.
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         locked_q <= 1'b0;
      end else if (ce_i) begin
         if (resume_i) begin
            locked_q <= 1'b1;
         end else if (unlock_hit || do_reset) begin
            locked_q <= 1'b0;
         end
      end
   end
   assign locked_o = locked_q;

   // ==========================================================
   // Endpoint configuration registers
   genvar g;
   generate
      for (g = 0; g < EP_NUM; g++) begin : g_ep
         wire hit = wr_ok && is_epw && (ep_idx == 4'(g));
         always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               ep_cfg_q[g] <= EPCFG_RST;
            end else if (ce_i) begin
               if (do_reset) begin
                  ep_cfg_q[g] <= EPCFG_RST;
               end else if (hit) begin
                  ep_cfg_q[g] <= wdata[7:0];
               end
            end
         end
         assign ep_cfg_o[g*EPCFG_W +: EPCFG_W] = ep_cfg_q[g];
      end
   endgenerate

   // ==========================================================
   // Endpoint buffers
   pkt_buffer u_in_buf (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .clear_i(do_reset),
      .hptr_rst_i(buf_rewind),
      .hwr_i(wr_inbuf),
      .hwdata_i(wdata),
      .hrd_i(1'b0),
      .hrdata_o(),
      .pop_i(in_pop_i),
      .byte_o(in_byte_o),
      .bvalid_o(in_valid_o),
      .usb_wr_i(1'b0),
      .usb_byte_i(8'h00),
      .usb_end_i(1'b0)
   );

   pkt_buffer u_out_buf (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .clear_i(do_reset),
      .hptr_rst_i(buf_rewind),
      .hwr_i(1'b0),
      .hwdata_i(16'h0000),
      .hrd_i(rd_outbuf),
      .hrdata_o(outbuf_word),
      .pop_i(1'b0),
      .byte_o(),
      .bvalid_o(),
      .usb_wr_i(out_wr_i),
      .usb_byte_i(out_byte_i),
      .usb_end_i(out_end_i)
   );
endmodule // usb_cmd_device

// file: rtl/usb_cmd_host.sv
// Host end of the two-phase command port: runs command and data strobes.
`timescale 1ns/10ps
module usb_cmd_host
   import usbcmd_pkg::*;
(
   input wire logic ref_clk_i,            // System clock, 200 MHz.
   input wire logic rst_b_i,              // Asynchronous reset, active low.
   input wire logic ce_i,                 // Clock enable, freezes all state.
   cmd_bus_if.host bus,                   // Parallel processor bus.
   input wire logic op_start_i,           // Pulse, start an access when idle.
   input wire logic [7:0] op_code_i,      // Command code.
   input wire logic op_write_i,           // Data phase direction, 1 = write.
   input wire logic [5:0] op_words_i,     // Data words, 0 = command only.
   input wire logic [15:0] wr_word_i,     // Next write word.
   output logic wr_take_o,                // Pulse, wr_word_i consumed.
   output logic [15:0] rd_word_o,         // Read word.
   output logic rd_valid_o,               // Pulse, rd_word_o valid.
   output logic busy_o                    // Access in progress.
);
   import usbcmd_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_STROBE = 3'b010,
      ST_GAP = 3'b100
   } state_t;

   state_t st_q;
   logic [5:0] left_q;
   logic dir_wr_q;
   logic data_rd_q;
   logic [1:0] cnt_q;

   wire start = (st_q == ST_IDLE) && op_start_i;
   wire strobe_end = (st_q == ST_STROBE) && (cnt_q == 2'h0);
   wire next_data = (st_q == ST_GAP) && (left_q != 6'h00);
   wire finish = (st_q == ST_GAP) && (left_q == 6'h00);

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q <= ST_IDLE;
         left_q <= 6'h00;
         dir_wr_q <= 1'b0;
         data_rd_q <= 1'b0;
         cnt_q <= 2'h0;
         bus.cs_b <= 1'b1;
         bus.rd_b <= 1'b1;
         bus.wr_b <= 1'b1;
         bus.cmd_data_select <= 1'b0;
         bus.hdata <= 16'h0000;
         bus.hdata_oe <= 1'b0;
         wr_take_o <= 1'b0;
         rd_word_o <= 16'h0000;
         rd_valid_o <= 1'b0;
         busy_o <= 1'b0;
      end else if (ce_i) begin
         wr_take_o <= 1'b0;
         rd_valid_o <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (start) begin
                  bus.cs_b <= 1'b0;
                  bus.wr_b <= 1'b0;
                  bus.cmd_data_select <= 1'b1;
                  bus.hdata <= {8'h00, op_code_i};
                  bus.hdata_oe <= 1'b1;
                  left_q <= op_words_i;
                  dir_wr_q <= op_write_i;
                  data_rd_q <= 1'b0;
                  cnt_q <= WR_STROBE_CYC - 2'h1;
                  busy_o <= 1'b1;
                  st_q <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               if (strobe_end) begin
                  bus.cs_b <= 1'b1;
                  bus.wr_b <= 1'b1;
                  bus.rd_b <= 1'b1;
                  bus.hdata_oe <= 1'b0;
                  if (data_rd_q) begin
                     rd_word_o <= bus.data_bus;
                     rd_valid_o <= 1'b1;
                  end
                  st_q <= ST_GAP;
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
            ST_GAP: begin
               if (finish) begin
                  busy_o <= 1'b0;
                  st_q <= ST_IDLE;
               end else if (next_data) begin
                  bus.cs_b <= 1'b0;
                  bus.cmd_data_select <= 1'b0;
                  left_q <= left_q - 6'h01;
                  data_rd_q <= !dir_wr_q;
                  if (dir_wr_q) begin
                     bus.wr_b <= 1'b0;
                     bus.hdata <= wr_word_i;
                     bus.hdata_oe <= 1'b1;
                     wr_take_o <= 1'b1;
                     cnt_q <= WR_STROBE_CYC - 2'h1;
                  end else begin
                     bus.rd_b <= 1'b0;
                     cnt_q <= RD_STROBE_CYC - 2'h1;
                  end
                  st_q <= ST_STROBE;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // usb_cmd_host

// file: rtl/usbcmd_pkg.sv
// Shared constants for the two-phase command port of the USB device controller.
package usbcmd_pkg;
   // ==========================================================
   // Widths and sizes
   localparam int DATA_W = 16;
   localparam int CODE_W = 8;
   localparam int EP_NUM = 16;
   localparam int EPCFG_W = 8;
   localparam int BUF_DEPTH = 32;
   localparam int BUF_AW = 5;
   localparam int BPTR_W = 6;
   localparam int WIDX_W = 2;
   // ==========================================================
   // Command codes
   localparam logic [7:0] CMD_EPCFG_WR_HI = 8'h02;
   localparam logic [7:0] CMD_EPCFG_RD_HI = 8'h03;
   localparam logic [7:0] CMD_ADDR_WR = 8'hb6;
   localparam logic [7:0] CMD_ADDR_RD = 8'hb7;
   localparam logic [7:0] CMD_MODE_WR = 8'hb8;
   localparam logic [7:0] CMD_MODE_RD = 8'hb9;
   localparam logic [7:0] CMD_HWCFG_WR = 8'hba;
   localparam logic [7:0] CMD_HWCFG_RD = 8'hbb;
   localparam logic [7:0] CMD_INTEN_WR = 8'hc2;
   localparam logic [7:0] CMD_INTEN_RD = 8'hc3;
   localparam logic [7:0] CMD_DMACFG_WR = 8'hf0;
   localparam logic [7:0] CMD_DMACFG_RD = 8'hf1;
   localparam logic [7:0] CMD_DMACNT_WR = 8'hf2;
   localparam logic [7:0] CMD_DMACNT_RD = 8'hf3;
   localparam logic [7:0] CMD_RESET_DEV = 8'hf6;
   localparam logic [7:0] CMD_UNLOCK = 8'hb0;
   localparam logic [7:0] CMD_INBUF_WR = 8'h01;
   localparam logic [7:0] CMD_OUTBUF_RD = 8'h10;
   localparam logic [15:0] UNLOCK_KEY = 16'haa37;
   // ==========================================================
   // Word counts of multi-word registers
   localparam logic [1:0] INTEN_WORDS = 2'h2;
   // ==========================================================
   // Values after reset
   localparam logic [7:0] EPCFG_RST = 8'h00;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [15:0] HWCFG_RST = 16'h0000;
   localparam logic [31:0] INTEN_RST = 32'h0000_0000;
   localparam logic [15:0] DMACFG_RST = 16'h0000;
   localparam logic [15:0] DMACNT_RST = 16'h0000;
   // ==========================================================
   // Strobe timing in cycles of ref_clk_i
   localparam logic [1:0] WR_STROBE_CYC = 2'h1;
   localparam logic [1:0] RD_STROBE_CYC = 2'h2;
endpackage

// file: tb/cmd_bus_checker.sv
// Assertions on the command bus between the host end and the device end.
`timescale 1ns/10ps
module cmd_bus_checker (
   input wire logic ref_clk_i, // System clock.
   input wire logic rst_b_i, // Reset, active low.
   input wire logic cs_b, // Chip select.
   input wire logic rd_b, // Read strobe.
   input wire logic wr_b, // Write strobe.
   input wire logic cmd_data_select, // Phase select.
   input wire logic [15:0] hdata, // Host data.
   input wire logic hdata_oe, // Host drives.
   input wire logic [15:0] ddata, // Device data.
   input wire logic ddata_oe, // Device drives.
   input wire logic [15:0] data_bus // Resolved lines.
);
   // ==========================================
   // Bus protocol
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_write_pulse: assert property ($fell(wr_b) |=> wr_b)
      else $error("write strobe length");
   a_read_pulse: assert property ($fell(rd_b) |=> !rd_b ##1 rd_b)
      else $error("read strobe length");
   a_device_answers: assert property (!cs_b && $fell(rd_b) |=> ddata_oe && data_bus == ddata)
      else $error("no read data");
   a_device_release: assert property ($rose(rd_b) |=> !ddata_oe)
      else $error("device holds bus");
   a_one_driver: assert property (!(hdata_oe && ddata_oe))
      else $error("bus contention");
   a_cmd_is_write: assert property (!cs_b && cmd_data_select |-> rd_b && !wr_b)
      else $error("command not a write");
   a_write_driven: assert property (!wr_b |-> !cs_b && hdata_oe && data_bus == hdata)
      else $error("write data not driven");
   a_select_held: assert property (!cs_b && $past(!cs_b) |-> $stable(cmd_data_select))
      else $error("select moved in strobe");
   a_oe_bounded: assert property (ddata_oe |-> !rd_b || $past(!rd_b))
      else $error("device drives unasked");
   cover property ($fell(wr_b) && cmd_data_select);
   cover property ($fell(wr_b) && !cmd_data_select);
   cover property ($fell(rd_b));
endmodule // cmd_bus_checker

// file: tb/usb_device_command_port_bench.sv
// Bench joining host end and device end over the command bus.
`timescale 1ns/10ps
module usb_device_command_port_bench;
   import usbcmd_pkg::*;
   logic clk = 0, rst_b = 0, st = 0, wr = 0, rsm = 0, pop = 0, owr = 0, oend = 0;
   logic [7:0] code = 8'h00, ob = 8'h00;
   logic [5:0] nw = 6'h00;
   logic [15:0] wq [8] = '{default: 16'h0000};
   logic [15:0] rq [$];
   int wi = 0, fail_count = 0, compares = 0, nsr = 0;
   logic take, rv, busy, lk, srst, iv;
   logic [15:0] rw, hw, dc, dn;
   logic [7:0] da, md, ib;
   logic [31:0] ie;
   logic [127:0] ep;
   logic [7:0] rc [5] = '{CMD_ADDR_WR, CMD_MODE_WR, CMD_HWCFG_WR, CMD_DMACFG_WR, CMD_DMACNT_WR};
   logic [15:0] rm [5] = '{16'h00ff, 16'h00ff, 16'hffff, 16'hffff, 16'hffff};
   wire [79:0] ov = {dn, dc, hw, 8'h00, md, 8'h00, da};
   always #2.5 clk = ~clk;
   cmd_bus_if bus ();
   usb_cmd_host usb_cmd_host_inst (.ref_clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1), .bus(bus),
      .op_start_i(st), .op_code_i(code), .op_write_i(wr), .op_words_i(nw),
      .wr_word_i(wq[wi]), .wr_take_o(take), .rd_word_o(rw), .rd_valid_o(rv), .busy_o(busy));
   usb_cmd_device usb_cmd_device_inst (.ref_clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1), .bus(bus),
      .resume_i(rsm), .locked_o(lk), .soft_reset_o(srst), .dev_addr_o(da), .mode_o(md),
      .hw_cfg_o(hw), .int_en_o(ie), .dma_cfg_o(dc), .dma_cnt_o(dn), .ep_cfg_o(ep),
      .in_pop_i(pop), .in_byte_o(ib), .in_valid_o(iv), .out_wr_i(owr), .out_byte_i(ob),
      .out_end_i(oend));
   cmd_bus_checker cmd_bus_checker_inst (.ref_clk_i(clk), .rst_b_i(rst_b), .cs_b(bus.cs_b),
      .rd_b(bus.rd_b), .wr_b(bus.wr_b), .cmd_data_select(bus.cmd_data_select),
      .hdata(bus.hdata), .hdata_oe(bus.hdata_oe), .ddata(bus.ddata),
      .ddata_oe(bus.ddata_oe), .data_bus(bus.data_bus));
   always @(posedge clk) begin
      if (take) wi <= wi + 1;
      if (rv) rq.push_back(rw);
      if (srst) nsr <= nsr + 1;
   end
   task automatic print_verdict();
      if (fail_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   // ==========================================
   // One access: command then n data words.
   task automatic op(input logic [7:0] c, input logic w, input logic [5:0] n);
      code = c; wr = w; nw = n; wi = 0; rq = {}; st = 1;
      @(posedge clk) #1 st = 0;
      for (int k = 0; busy !== 1'b0; k++) begin
         if (k > 300) begin fail_count++; print_verdict(); end
         @(posedge clk) #1;
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1 rst_b = 1;
      for (int i = 0; i < 5; i++) begin
         wq[0] = 16'h5ac3 + 16'(i);
         op(rc[i], 1, 1);
         op(rc[i] + 8'h01, 0, 1);
         chk("reg read", {16'h0, rq[0]}, {16'h0, wq[0] & rm[i]});
         chk("reg port", {16'h0, ov[16*i +: 16]}, {16'h0, wq[0] & rm[i]});
      end
      wq[0] = 16'h1234; wq[1] = 16'habcd;
      op(CMD_INTEN_WR, 1, 2);
      chk("int_en", ie, 32'habcd_1234);
      op(CMD_INTEN_RD, 0, 2);
      chk("int_en read", {rq[1], rq[0]}, 32'habcd_1234);
      for (int n = 0; n < 16; n++) begin
         wq[0] = 16'h0040 + 16'(n);
         op(8'h20 + 8'(n), 1, 1);
         chk("ep cfg", {24'h0, ep[8*n +: 8]}, 32'h40 + n);
      end
      for (int n = 0; n < 16; n++) begin
         op(8'h30 + 8'(n), 0, 1);
         chk("ep read", {16'h0, rq[0]}, 32'h40 + n);
      end
      wq[0] = 16'h0077; op(8'h55, 1, 1);
      chk("unknown code", {ie[15:0], 8'h00, da}, 32'h1234_00c3);
      op(8'h55, 0, 1);
      chk("unknown read", {16'h0, rq[0]}, 0);
      rsm = 1; @(posedge clk) #1 rsm = 0;
      chk("locked", {31'h0, lk}, 32'h1);
      wq[0] = 16'h0011; op(CMD_ADDR_WR, 1, 1);
      chk("write blocked", {24'h0, da}, 32'hc3);
      wq[0] = UNLOCK_KEY; op(CMD_UNLOCK, 1, 1);
      op(CMD_ADDR_WR, 1, 1);
      chk("unlocked", {lk, 23'h0, da}, 32'h37);
      wq[0] = 16'h0003; wq[1] = 16'h2211; wq[2] = 16'h5533;
      op(CMD_INBUF_WR, 1, 3);
      pop = 1;
      for (int b = 0; b < 4; b++) begin
         @(posedge clk) #1;
         if (b == 3) pop = 0;
         chk("in byte", {iv, 23'h0, iv ? ib : 8'h00}, b < 3 ? {1'b1, 23'h0, 8'h11 * 8'(b + 1)} : 0);
      end
      owr = 1;
      for (int b = 0; b < 3; b++) begin ob = 8'ha0 + 8'(b); @(posedge clk) #1; end
      owr = 0; oend = 1;
      @(posedge clk) #1 oend = 0;
      op(CMD_OUTBUF_RD, 0, 3);
      chk("out words", {rq[0], rq[1]}, 32'h0003_a1a0);
      chk("out last", {24'h0, rq[2][7:0]}, 32'ha2);
      op(CMD_RESET_DEV, 1, 0);
      chk("soft reset", {ie[31:8], da}, 0);
      chk("reset pulse", nsr, 1);
      print_verdict();
   end
endmodule // usb_device_command_port_bench
